// *** hdl/dra_regs.svh ***
// register map, field positions and timing counts of the rx address/status block
//
// Notes on behaviour
// R1 - high mask select 0: sap vs first, second, group; 1: first masked by second, group
// R2 - low mask select 0: ep vs first, second, group; 1: first masked by second, group
// R3 - group service point is FC or FE, group endpoint is FF
// R4 - both endpoint values used except transparent 0, 1 and extended transparent
// R5 - one-byte mode: first endpoint is command address, second is response address
// R6 - message byte count is 12 bits, low byte and high nibble in two registers
// R7 - length exceeded flag set when a message passes 4095 bytes
// R8 - counts valid after frame end or pool full, held until release or clear
// R9 - frame invalid when bits between flag and end are not a multiple of 8
// R10 - byte lost flag when a frame byte could not be stored, buffer full
// R11 - frame check result 1 when crc correct, 0 when incorrect
// R12 - aborted flag when seven ones seen before the closing flag
// R13 - codes: one-byte 010 ep flag first/second; two-byte 011 sa and group/programmed ep
// R14 - transparent 1 (111) sa code; transparent 2 (101) ep group/programmed; 11 reserved
// R15 - equal first and second sap with group ep reported as sa code 10 only
// R16 - command/response bit is bit 1 of the first address byte
// R17 - result register shows last frame; its copy ends every stored frame
// R18 - loopback with serial active routes tx bits to rx, far rx ignored
// R19 - software keeps the extension bit of both endpoint registers at 1
// R20 - comparison chosen by the three bit frame transfer mode field
// R21 - release command after frame end or pool full frees the buffer space
// R22 - compare on first one or two bytes, match code latched before frame end
`ifndef DRA_REGS_SVH
`define DRA_REGS_SVH

`define DRA_ADDR_BUFFER       8'h00
`define DRA_ADDR_COMMAND      8'h21
`define DRA_ADDR_MODE         8'h22
`define DRA_ADDR_FIRST_SP     8'h25
`define DRA_ADDR_SECOND_SP    8'h26
`define DRA_ADDR_COUNT_HIGH   8'h27
`define DRA_ADDR_ENDPOINT_ONE 8'h27
`define DRA_ADDR_RESULT       8'h28
`define DRA_ADDR_COUNT_LOW    8'h29
`define DRA_ADDR_ENDPOINT_TWO 8'h29
`define DRA_ADDR_TEST         8'h2b

`define DRA_RST_SP            8'hfc
`define DRA_RST_EP            8'hff
`define DRA_RST_RESULT        8'h0f
`define DRA_RST_MODE          8'hc0
`define DRA_RST_TEST          8'h00

`define DRA_CMD_RELEASE_BIT   7
`define DRA_CMD_CLEAR_BIT     6
`define DRA_MODE_MSB          7
`define DRA_MODE_LSB          5
`define DRA_MASK_SEL_BIT      0
`define DRA_LOOP_BIT          0
`define DRA_CR_BIT            1
`define DRA_RESULT_LOST_BIT   6

`define DRA_GROUP_SP          6'h3f
`define DRA_GROUP_EP          7'h7f
`define DRA_SA_SECOND         2'b00
`define DRA_SA_GROUP          2'b01
`define DRA_SA_FIRST          2'b10

`define DRA_CRC_INIT          16'hffff
`define DRA_CRC_POLY          16'h8408
`define DRA_CRC_GOOD          16'hf0b8

`define DRA_ONES_MAX          3'd7
`define DRA_FLAG_ONES         3'd6
`define DRA_STUFF_ONES        3'd5
`define DRA_FLAG_TAIL         3'd6
`define DRA_ABORT_TAIL        3'd5
`define DRA_SHF_LAST          3'd7

`define DRA_BUF_AW            6
`define DRA_BUF_DEPTH         7'h40
`define DRA_POOL_LAST         5'h1f
`define DRA_COUNT_MAX         12'hfff

`endif

// *** hdl/dra_pkg.sv ***
// types shared by the rx address/status block
package dra_pkg;

  typedef enum logic [2:0] {
    MODE_RSVD0     = 3'b000,
    MODE_RSVD1     = 3'b001,
    MODE_ONE_BYTE  = 3'b010,
    MODE_TWO_BYTE  = 3'b011,
    MODE_EXT_TRANS = 3'b100,
    MODE_TRANS2    = 3'b101,
    MODE_TRANS0    = 3'b110,
    MODE_TRANS1    = 3'b111
  } dra_mode_e;

  typedef enum logic [1:0] {
    ST_HUNT  = 2'b00,
    ST_FRAME = 2'b01,
    ST_CLOSE = 2'b10
  } dra_rx_state_e;

  typedef struct packed {
    dra_rx_state_e st;
    dra_rx_state_e after;
    logic [2:0]    ones;
    logic [7:0]    shf;
    logic [2:0]    shf_cnt;
    logic [7:0]    pend;
    logic          pend_v;
    logic          had_byte;
    logic [1:0]    idx;
    logic [7:0]    byte1;
    logic [7:0]    byte2;
    logic [15:0]   crc;
    logic          byte_lost;
    logic [11:0]   cnt;
    logic          len_over;
    logic [4:0]    pool_cnt;
    logic          keep;
    logic [7:0]    fin_status;
    logic [7:0]    result;
    logic [11:0]   cnt_hold;
    logic          len_over_hold;
    logic          locked;
    logic [6:0]    wr_ptr;
    logic [6:0]    rd_ptr;
    logic [6:0]    free_ptr;
    logic [7:0]    first_sp;
    logic [7:0]    second_sp;
    logic [7:0]    first_ep;
    logic [7:0]    second_ep;
    logic [7:0]    mode_reg;
    logic [7:0]    test_reg;
    logic [7:0]    rdata;
    logic          rd_buf;
    logic          frame_end;
    logic          pool_full;
  } dra_state_s;

endpackage

// *** hdl/dra_rx_buffer.sv ***
// receive buffer memory, registered read data
`timescale 1ns/1ns
`include "dra_regs.svh"
module dra_rx_buffer (
  input  wire logic                     clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     we_i,
  input  wire logic [`DRA_BUF_AW-1:0]   waddr_i,
  input  wire logic [7:0]               wdata_i,
  input  wire logic [`DRA_BUF_AW-1:0]   raddr_i,
  output logic      [7:0]               rdata_o
);
  import dra_pkg::*;

  logic [7:0] mem [0:(1<<`DRA_BUF_AW)-1];

  // array left without reset so it maps onto plain ram
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule

// *** hdl/dra_addr_match.sv ***
// address comparison of the first one or two bytes of a frame
`timescale 1ns/1ns
`include "dra_regs.svh"
module dra_addr_match (
  input  wire logic [2:0] mode_i,
  input  wire logic [7:0] byte1_i,
  input  wire logic [7:0] byte2_i,
  input  wire logic [7:0] first_sp_i,
  input  wire logic [7:0] second_sp_i,
  input  wire logic [7:0] first_ep_i,
  input  wire logic [7:0] second_ep_i,
  output logic      [1:0] sa_code_o,
  output logic            ep_flag_o,
  output logic            accept_o,
  output logic      [1:0] addr_len_o
);
  import dra_pkg::*;

  logic [5:0] sp;
  logic [6:0] ep;
  logic       mask_h;
  logic       mask_l;
  logic       sp1_hit;
  logic       sp2_hit;
  logic       spg_hit;
  logic       ep1_hit;
  logic       ep2_hit;
  logic       epg_hit;

  assign sp     = byte1_i[7:2];
  // one-byte mode compares the only byte against the endpoint values
  assign ep     = (mode_i == MODE_ONE_BYTE) ? byte1_i[7:1] : byte2_i[7:1];
  assign mask_h = first_sp_i[`DRA_MASK_SEL_BIT];
  assign mask_l = second_sp_i[`DRA_MASK_SEL_BIT];

  assign sp1_hit = mask_h ? (((sp ^ first_sp_i[7:2]) & ~second_sp_i[7:2]) == 6'h00)
                          : (sp == first_sp_i[7:2]); // [R1]
  assign sp2_hit = !mask_h && (sp == second_sp_i[7:2]); // [R1]
  assign spg_hit = (sp == `DRA_GROUP_SP); // [R3]
  assign ep1_hit = mask_l ? (((ep ^ first_ep_i[7:1]) & ~second_ep_i[7:1]) == 7'h00)
                          : (ep == first_ep_i[7:1]); // [R2]
  assign ep2_hit = !mask_l && (ep == second_ep_i[7:1]); // [R2] [R4]
  assign epg_hit = (ep == `DRA_GROUP_EP); // [R3]

  always_comb begin
    // first wins so equal first/second never yields code 00 in the compare modes [R15]
    sa_code_o = sp1_hit ? `DRA_SA_FIRST : (sp2_hit ? `DRA_SA_SECOND : `DRA_SA_GROUP);
    ep_flag_o = 1'b0;
    accept_o  = 1'b1;
    addr_len_o = 2'd0;
    unique case (mode_i) // [R20]
      MODE_ONE_BYTE: begin
        ep_flag_o  = ep1_hit; // [R5] [R13]
        accept_o   = ep1_hit || ep2_hit;
        addr_len_o = 2'd1;
      end
      MODE_TWO_BYTE: begin
        ep_flag_o  = ep1_hit || ep2_hit; // [R13]
        accept_o   = (sp1_hit || sp2_hit || spg_hit) && (ep1_hit || ep2_hit || epg_hit);
        addr_len_o = 2'd2;
      end
      MODE_TRANS1: begin
        accept_o   = sp1_hit || sp2_hit || spg_hit; // [R14]
        addr_len_o = 2'd1;
      end
      MODE_TRANS2: begin
        ep_flag_o  = ep1_hit || ep2_hit; // [R14]
        accept_o   = ep1_hit || ep2_hit || epg_hit;
        addr_len_o = 2'd2;
      end
      MODE_RSVD0, MODE_RSVD1, MODE_EXT_TRANS, MODE_TRANS0: begin
        sa_code_o = `DRA_SA_SECOND; // no compare, every frame kept [R4]
      end
    endcase
  end

endmodule

// *** hdl/dra_rx_top.sv ***
// receive side: deframing, address match, byte count, status and buffer
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`include "dra_regs.svh"
module dra_rx_top (
  input  wire logic       SYS_CLK_I,
  input  wire logic       RESET_N_I,
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  input  wire logic       RX_BIT_I,
  input  wire logic       RX_BIT_VALID_I,
  input  wire logic       TX_BIT_I,
  input  wire logic       TX_BIT_VALID_I,
  input  wire logic       SERIAL_ACTIVE_I,
  output logic            FRAME_END_O,
  output logic            POOL_FULL_O
);
  import dra_pkg::*;

  dra_state_s s;
  dra_state_s n;

  logic [7:0]  mem_q;
  logic        mem_we;
  logic [7:0]  mem_wdata;
  logic [1:0]  sa_code;
  logic        ep_flag;
  logic        accept;
  logic [1:0]  addr_len;
  logic        loop_on;
  logic        bit_d;
  logic        bit_v;
  logic        buf_full;
  logic [2:0]  ones_inc;
  logic [7:0]  shf_new;
  logic [15:0] crc_fin;
  logic        shift_req;
  logic        fwd_req;
  logic [7:0]  fwd_byte;
  logic        end_req;
  logic        end_abort;
  logic        open_req;
  logic        push_req;
  logic        push_is_data;
  logic [7:0]  push_data;
  logic        latch_req;
  logic        frame_reset;
  logic        frame_ok;
  logic [7:0]  close_status;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ `DRA_CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  dra_addr_match i_dra_addr_match (
    .mode_i      (s.mode_reg[`DRA_MODE_MSB:`DRA_MODE_LSB]),
    .byte1_i     (s.byte1),
    .byte2_i     (s.byte2),
    .first_sp_i  (s.first_sp),
    .second_sp_i (s.second_sp),
    .first_ep_i  (s.first_ep),
    .second_ep_i (s.second_ep),
    .sa_code_o   (sa_code),
    .ep_flag_o   (ep_flag),
    .accept_o    (accept),
    .addr_len_o  (addr_len)
  );

  dra_rx_buffer i_dra_rx_buffer (
    .clk_i     (SYS_CLK_I),
    .reset_n_i (RESET_N_I),
    .we_i      (mem_we),
    .waddr_i   (s.wr_ptr[`DRA_BUF_AW-1:0]),
    .wdata_i   (mem_wdata),
    .raddr_i   (s.rd_ptr[`DRA_BUF_AW-1:0]),
    .rdata_o   (mem_q)
  );

  // loopback only while the serial side is up [R18]
  assign loop_on  = s.test_reg[`DRA_LOOP_BIT] && SERIAL_ACTIVE_I;
  assign bit_d    = loop_on ? TX_BIT_I : RX_BIT_I; // [R18]
  assign bit_v    = loop_on ? TX_BIT_VALID_I : RX_BIT_VALID_I; // [R18]
  assign buf_full = (7'(s.wr_ptr - s.free_ptr) == `DRA_BUF_DEPTH);

  assign RDATA_O     = s.rd_buf ? mem_q : s.rdata;
  assign FRAME_END_O = s.frame_end;
  assign POOL_FULL_O = s.pool_full;

  always_comb begin
    n            = s;
    ones_inc     = 3'd0;
    shf_new      = 8'h00;
    crc_fin      = s.crc;
    shift_req    = 1'b0;
    fwd_req      = 1'b0;
    fwd_byte     = 8'h00;
    end_req      = 1'b0;
    end_abort    = 1'b0;
    open_req     = 1'b0;
    push_req     = 1'b0;
    push_is_data = 1'b0;
    push_data    = 8'h00;
    latch_req    = 1'b0;
    frame_reset  = 1'b0;
    frame_ok     = 1'b0;
    close_status = 8'h00;
    mem_we       = 1'b0;
    mem_wdata    = 8'h00;
    n.frame_end  = 1'b0;
    n.pool_full  = 1'b0;
    n.rd_buf     = 1'b0;
    n.rdata      = 8'h00;

    // register port, read data stand one cycle after the strobe
    if (RD_I) begin
      case (ADDR_I)
        `DRA_ADDR_BUFFER: begin
          n.rd_buf = 1'b1;
          if (s.rd_ptr != s.wr_ptr) begin
            n.rd_ptr = 7'(s.rd_ptr + 7'd1);
          end
        end
        `DRA_ADDR_COUNT_HIGH: n.rdata = {3'h0, s.len_over_hold, s.cnt_hold[11:8]}; // [R6] [R7]
        `DRA_ADDR_COUNT_LOW:  n.rdata = s.cnt_hold[7:0]; // [R6]
        `DRA_ADDR_RESULT:     n.rdata = s.result; // [R17]
        `DRA_ADDR_MODE:       n.rdata = s.mode_reg;
        `DRA_ADDR_TEST:       n.rdata = s.test_reg;
        default:              n.rdata = 8'h00;
      endcase
    end
    if (WR_I) begin
      case (ADDR_I)
        `DRA_ADDR_FIRST_SP:     n.first_sp  = WDATA_I;
        `DRA_ADDR_SECOND_SP:    n.second_sp = WDATA_I;
        // extension bit stored as written; software keeps it at 1 [R19]
        `DRA_ADDR_ENDPOINT_ONE: n.first_ep  = WDATA_I;
        `DRA_ADDR_ENDPOINT_TWO: n.second_ep = WDATA_I;
        `DRA_ADDR_MODE:         n.mode_reg  = WDATA_I;
        `DRA_ADDR_TEST:         n.test_reg  = WDATA_I;
        default: begin
        end
      endcase
    end

    // bit level deframing: flags, stuffed zeros, aborts
    unique case (s.st)
      ST_HUNT, ST_FRAME: begin
        if (bit_v) begin
          if (bit_d) begin
            ones_inc = (s.ones == `DRA_ONES_MAX) ? s.ones : 3'(s.ones + 3'd1);
            n.ones   = ones_inc;
            if (ones_inc == `DRA_ONES_MAX) begin
              if (s.st == ST_FRAME) begin
                end_req   = 1'b1;
                end_abort = 1'b1; // [R12]
              end
              n.st = ST_HUNT;
            end else if (ones_inc <= `DRA_STUFF_ONES && s.st == ST_FRAME) begin
              shift_req = 1'b1;
            end
          end else begin
            n.ones = 3'd0;
            if (s.ones == `DRA_FLAG_ONES) begin
              if (s.st == ST_FRAME && s.had_byte) begin
                end_req = 1'b1;
              end else begin
                open_req = 1'b1;
              end
              n.st = ST_FRAME;
            end else if (s.ones != `DRA_STUFF_ONES && s.st == ST_FRAME) begin
              shift_req = 1'b1;
            end
          end
        end
      end
      ST_CLOSE: begin
        // the status byte gets its own cycle after the last data byte
        if (s.keep) begin
          close_status = s.fin_status;
          close_status[`DRA_RESULT_LOST_BIT] = s.byte_lost; // [R10]
          push_req    = 1'b1;
          push_data   = close_status; // [R17]
          n.result    = close_status; // [R17]
          n.frame_end = 1'b1;
          latch_req   = 1'b1; // [R8]
        end
        frame_reset = 1'b1;
        n.st        = s.after;
      end
      default: n.st = ST_HUNT;
    endcase

    // one byte lag keeps the closing flag bits out of the data
    if (shift_req) begin
      shf_new   = {bit_d, s.shf[7:1]};
      n.shf     = shf_new;
      n.shf_cnt = 3'(s.shf_cnt + 3'd1);
      if (s.shf_cnt == `DRA_SHF_LAST) begin
        n.pend     = shf_new;
        n.pend_v   = 1'b1;
        n.had_byte = 1'b1;
        if (s.pend_v) begin
          fwd_req  = 1'b1;
          fwd_byte = s.pend;
        end
      end
    end

    if (end_req) begin
      if (s.pend_v) begin
        fwd_req  = 1'b1;
        fwd_byte = s.pend;
        crc_fin  = crc_byte(s.crc, s.pend);
      end
      n.pend_v = 1'b0;
      frame_ok = (s.shf_cnt == (end_abort ? `DRA_ABORT_TAIL : `DRA_FLAG_TAIL)); // [R9]
      // match code taken from the registered address bytes [R22]
      n.fin_status = {frame_ok, 1'b0, (crc_fin == `DRA_CRC_GOOD), end_abort,
                      sa_code, s.byte1[`DRA_CR_BIT], ep_flag}; // [R11] [R12] [R13] [R16]
      n.keep  = accept && (s.idx >= addr_len); // [R22]
      n.after = end_abort ? ST_HUNT : ST_FRAME;
      n.st    = ST_CLOSE;
    end

    // address bytes are compared, payload bytes of a matching frame are stored
    if (fwd_req) begin
      n.crc = crc_byte(s.crc, fwd_byte); // [R11]
      if (s.idx == 2'd0) begin
        n.byte1 = fwd_byte; // [R22]
      end
      if (s.idx == 2'd1) begin
        n.byte2 = fwd_byte; // [R22]
      end
      if (s.idx != 2'd2) begin
        n.idx = 2'(s.idx + 2'd1);
      end
      if (s.idx >= addr_len && accept) begin
        push_req     = 1'b1;
        push_is_data = 1'b1;
        push_data    = fwd_byte;
      end
    end

    if (push_req) begin
      if (buf_full) begin
        n.byte_lost = 1'b1; // [R10]
      end else begin
        mem_we    = 1'b1;
        mem_wdata = push_data;
        n.wr_ptr  = 7'(s.wr_ptr + 7'd1);
        if (push_is_data) begin
          n.pool_cnt = 5'(s.pool_cnt + 5'd1);
          if (s.pool_cnt == `DRA_POOL_LAST) begin
            n.pool_full = 1'b1;
            latch_req   = 1'b1; // [R8]
          end
        end
      end
      n.cnt = 12'(s.cnt + 12'd1); // [R6]
      if (s.cnt == `DRA_COUNT_MAX) begin
        n.len_over = 1'b1; // [R7]
      end
    end

    // counts frozen until the release or clear command [R8]
    if (latch_req && !s.locked) begin
      n.cnt_hold      = n.cnt;
      n.len_over_hold = n.len_over;
      n.locked        = 1'b1;
    end

    if (open_req) begin
      frame_reset = 1'b1;
    end
    if (frame_reset) begin
      n.shf_cnt   = 3'd0;
      n.pend_v    = 1'b0;
      n.had_byte  = 1'b0;
      n.idx       = 2'd0;
      n.crc       = `DRA_CRC_INIT;
      n.byte_lost = 1'b0;
      n.cnt       = 12'h000;
      n.len_over  = 1'b0;
      n.pool_cnt  = 5'h00;
    end

    if (WR_I && ADDR_I == `DRA_ADDR_COMMAND) begin
      if (WDATA_I[`DRA_CMD_RELEASE_BIT]) begin
        n.free_ptr = s.rd_ptr; // [R21]
        n.locked   = 1'b0; // [R8]
      end
      // clear drops any frame in flight and empties the buffer
      if (WDATA_I[`DRA_CMD_CLEAR_BIT]) begin
        n.st            = ST_HUNT;
        n.ones          = 3'd0;
        n.wr_ptr        = 7'h00;
        n.rd_ptr        = 7'h00;
        n.free_ptr      = 7'h00;
        n.locked        = 1'b0;
        n.cnt_hold      = 12'h000;
        n.len_over_hold = 1'b0;
        n.shf_cnt       = 3'd0;
        n.pend_v        = 1'b0;
        n.had_byte      = 1'b0;
        n.idx           = 2'd0;
        n.crc           = `DRA_CRC_INIT;
        n.byte_lost     = 1'b0;
        n.cnt           = 12'h000;
        n.len_over      = 1'b0;
        n.pool_cnt      = 5'h00;
        n.frame_end     = 1'b0;
        n.pool_full     = 1'b0;
        mem_we          = 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s           <= '0;
      s.crc       <= `DRA_CRC_INIT;
      s.result    <= `DRA_RST_RESULT;
      s.first_sp  <= `DRA_RST_SP;
      s.second_sp <= `DRA_RST_SP;
      s.first_ep  <= `DRA_RST_EP;
      s.second_ep <= `DRA_RST_EP;
      s.mode_reg  <= `DRA_RST_MODE;
      s.test_reg  <= `DRA_RST_TEST;
    end else begin
      s <= n;
    end
  end

endmodule

// *** testbench/dra_rx_checker.sv ***
// port assertions for the rx address/status block
`timescale 1ns/1ns
module dra_rx_checker (
  input  wire logic       SYS_CLK_I,
  input  wire logic       RESET_N_I,
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  input  wire logic [7:0] RDATA_O,
  input  wire logic       RX_BIT_VALID_I,
  input  wire logic       TX_BIT_VALID_I,
  input  wire logic       FRAME_END_O,
  input  wire logic       POOL_FULL_O
);
  logic       seen_end_reg;
  logic [2:0] mode_reg;
  logic       loop_reg;
  logic       readable;
  logic       any_bit;
  assign readable = ADDR_I inside {8'h00, 8'h22, 8'h27, 8'h28, 8'h29, 8'h2b};
  assign any_bit  = RX_BIT_VALID_I | TX_BIT_VALID_I;
  // shadow copies of what software wrote and a frame-end-seen flag, to judge read-back
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      seen_end_reg <= 1'b0;
      mode_reg     <= 3'h6;
      loop_reg     <= 1'b0;
    end else begin
      if (FRAME_END_O) seen_end_reg <= 1'b1;
      if (WR_I && ADDR_I == 8'h22) mode_reg <= WDATA_I[7:5];
      if (WR_I && ADDR_I == 8'h2b) loop_reg <= WDATA_I[0];
    end
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  end_pulse_a: assert property ($rose(FRAME_END_O) |=> !FRAME_END_O [*8])
    else $error("frame end pulse too long");
  pool_pulse_a: assert property (POOL_FULL_O |=> !POOL_FULL_O)
    else $error("pool full pulse too long");
  end_cause_a: assert property (FRAME_END_O |-> $past(any_bit, 2))
    else $error("frame end without closing bit");
  rd_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data outside read slot");
  unmapped_a: assert property (RD_I && !readable |=> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  reset_result_a: assert property (RD_I && ADDR_I == 8'h28 && !seen_end_reg
                                   |=> RDATA_O == 8'h0f)
    else $error("result reset value wrong");
  mode_back_a: assert property (RD_I && ADDR_I == 8'h22 |=> RDATA_O[7:5] == mode_reg)
    else $error("mode read back wrong");
  loop_back_a: assert property (RD_I && ADDR_I == 8'h2b |=> RDATA_O[0] == loop_reg)
    else $error("loop bit read back wrong");
  count_high_a: assert property (RD_I && ADDR_I == 8'h27 |=> RDATA_O[7:5] == 3'h0)
    else $error("count high spare bits set");
endmodule
bind dra_rx_top dra_rx_checker i_dra_rx_checker (.SYS_CLK_I, .RESET_N_I, .ADDR_I, .WDATA_I,
  .WR_I, .RD_I, .RDATA_O, .RX_BIT_VALID_I, .TX_BIT_VALID_I, .FRAME_END_O, .POOL_FULL_O);

// *** testbench/dra_l1_model.sv ***
// layer 1 side model: sends hdlc frames bit by bit
`timescale 1ns/1ns
module dra_l1_model (
  input  wire logic clk_i,
  output logic      bit_o,
  output logic      valid_o
);
  logic [15:0] crc;
  int          ones;
  initial begin
    bit_o = 1'b0;
    valid_o = 1'b0;
  end
  // strobes two cycles apart, the closest the receiver accepts
  task automatic put_bit(input logic b);
    @(posedge clk_i);
    bit_o <= b;
    valid_o <= 1'b1;
    @(posedge clk_i);
    bit_o <= ~b;
    valid_o <= 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] v, input bit raw);
    for (int i = 0; i < 8; i++) begin
      put_bit(v[i]);
      ones = (v[i] && !raw) ? ones + 1 : 0;
      if (ones == 5) begin
        put_bit(1'b0);
        ones = 0;
      end
    end
  endtask
  task automatic send_frame(input logic [7:0] a1, a2, input int nd, input bit bad);
    logic [7:0] b;
    crc = 16'hffff;
    ones = 0;
    put_byte(8'h7e, 1'b1);
    for (int i = 0; i < nd + 2; i++) begin
      b = (i == 0) ? a1 : (i == 1) ? a2 : 8'h30 + i[7:0];
      for (int k = 0; k < 8; k++)
        crc = (crc[0] ^ b[k]) ? (crc >> 1) ^ 16'h8408 : crc >> 1;
      put_byte(b, 1'b0);
    end
    crc = ~crc ^ {15'h0, bad};
    put_byte(crc[7:0], 1'b0);
    put_byte(crc[15:8], 1'b0);
    put_byte(8'h7e, 1'b1);
  endtask
endmodule

// *** testbench/tb_dra_rx_top.sv ***
// testbench for the rx address/status block
`timescale 1ns/1ns
`include "dra_regs.svh"
module tb_dra_rx_top;
  import dra_pkg::*;
  logic       SYS_CLK_I = 1'b0;
  logic       RESET_N_I = 1'b0;
  logic [7:0] ADDR_I = 8'h00;
  logic [7:0] WDATA_I = 8'h00;
  logic       WR_I = 1'b0;
  logic       RD_I = 1'b0;
  logic [7:0] RDATA_O;
  logic       RX_BIT_I;
  logic       RX_BIT_VALID_I;
  logic       TX_BIT_I;
  logic       TX_BIT_VALID_I;
  logic       SERIAL_ACTIVE_I = 1'b1;
  logic       FRAME_END_O;
  logic       POOL_FULL_O;
  logic [7:0] v;
  int         err_total = 0;
  int         cmp_count = 0;
  int         ends = 0;
  int         pools = 0;
  dra_rx_top i_dra_rx_top (.SYS_CLK_I, .RESET_N_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
    .RX_BIT_I, .RX_BIT_VALID_I, .TX_BIT_I, .TX_BIT_VALID_I, .SERIAL_ACTIVE_I, .FRAME_END_O,
    .POOL_FULL_O);
  dra_l1_model i_dra_l1_model_rx (.clk_i(SYS_CLK_I), .bit_o(RX_BIT_I), .valid_o(RX_BIT_VALID_I));
  dra_l1_model i_dra_l1_model_tx (.clk_i(SYS_CLK_I), .bit_o(TX_BIT_I), .valid_o(TX_BIT_VALID_I));
  always #50 SYS_CLK_I = ~SYS_CLK_I;
  always @(posedge SYS_CLK_I) begin
    if (FRAME_END_O === 1'b1) ends++;
    if (POOL_FULL_O === 1'b1) pools++;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge SYS_CLK_I);
    WR_I <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge SYS_CLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge SYS_CLK_I);
    RD_I <= 1'b0;
    #1 d = RDATA_O;
  endtask
  // loopback sends a bad-crc copy on the far side, which must be ignored
  task automatic frame(input logic [7:0] a1, a2, input int nd, input bit bad, lp,
                       input logic [7:0] exp, mask, cnt);
    int n;
    n = ends;
    if (lp) fork
      i_dra_l1_model_tx.send_frame(a1, a2, nd, bad);
      i_dra_l1_model_rx.send_frame(a1, a2, nd, 1'b1);
    join else i_dra_l1_model_rx.send_frame(a1, a2, nd, bad);
    for (int k = 0; k < 50 && ends == n; k++) @(posedge SYS_CLK_I);
    chk(8'(ends - n), 8'h01);
    rd(`DRA_ADDR_RESULT, v);
    chk(v & mask, exp);
    rd(`DRA_ADDR_COUNT_HIGH, v);
    chk(v, 8'h00);
    rd(`DRA_ADDR_COUNT_LOW, v);
    chk(v, cnt);
    for (int k = 1; k < cnt; k++) rd(`DRA_ADDR_BUFFER, v);
    rd(`DRA_ADDR_BUFFER, v);
    chk(v & mask, exp);
    wr(`DRA_ADDR_COMMAND, 8'h80);
    $display("test done: frame result %h", exp);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge SYS_CLK_I);
    err_total++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge SYS_CLK_I);
    RESET_N_I <= 1'b1;
    rd(`DRA_ADDR_RESULT, v);
    chk(v, `DRA_RST_RESULT);
    rd(`DRA_ADDR_COUNT_LOW, v);
    chk(v, 8'h00);
    rd(8'h30, v);
    chk(v, 8'h00);
    rd(`DRA_ADDR_MODE, v);
    chk(v, `DRA_RST_MODE);
    $display("test done: reset values");
    wr(`DRA_ADDR_FIRST_SP, 8'h14);
    wr(`DRA_ADDR_SECOND_SP, 8'h40);
    wr(`DRA_ADDR_ENDPOINT_ONE, 8'h25);
    wr(`DRA_ADDR_ENDPOINT_TWO, 8'h45);
    wr(`DRA_ADDR_MODE, {MODE_TWO_BYTE, 5'h00});
    frame(8'h16, 8'h25, 1, 1'b0, 1'b0, 8'hab, 8'hff, 8'h04);
    frame(8'h40, 8'h45, 3, 1'b0, 1'b0, 8'ha1, 8'hff, 8'h06);
    frame(8'hfc, 8'hff, 1, 1'b0, 1'b0, 8'ha4, 8'hff, 8'h04);
    frame(8'h16, 8'h25, 1, 1'b1, 1'b0, 8'h8b, 8'hff, 8'h04);
    wr(`DRA_ADDR_TEST, 8'h01);
    rd(`DRA_ADDR_TEST, v);
    chk({7'h00, v[0]}, 8'h01);
    frame(8'h16, 8'h25, 1, 1'b0, 1'b1, 8'hab, 8'hff, 8'h04);
    // loop bit set but serial side down: far rx must still be taken
    SERIAL_ACTIVE_I <= 1'b0;
    frame(8'h16, 8'h25, 1, 1'b0, 1'b0, 8'hab, 8'hff, 8'h04);
    SERIAL_ACTIVE_I <= 1'b1;
    wr(`DRA_ADDR_TEST, 8'h00);
    wr(`DRA_ADDR_SECOND_SP, 8'h14);
    frame(8'h16, 8'hff, 1, 1'b0, 1'b0, 8'haa, 8'hff, 8'h04);
    wr(`DRA_ADDR_FIRST_SP, 8'h15);
    wr(`DRA_ADDR_SECOND_SP, 8'h0c);
    frame(8'h18, 8'h25, 1, 1'b0, 1'b0, 8'ha9, 8'hff, 8'h04);
    wr(`DRA_ADDR_MODE, {MODE_ONE_BYTE, 5'h00});
    frame(8'h25, 8'h31, 0, 1'b0, 1'b0, 8'ha1, 8'hf3, 8'h04);
    frame(8'h45, 8'h31, 0, 1'b0, 1'b0, 8'ha0, 8'hf3, 8'h04);
    wr(`DRA_ADDR_MODE, {MODE_TRANS1, 5'h00});
    frame(8'h16, 8'h25, 1, 1'b0, 1'b0, 8'haa, 8'hfe, 8'h05);
    wr(`DRA_ADDR_MODE, {MODE_TRANS2, 5'h00});
    frame(8'h16, 8'hff, 1, 1'b0, 1'b0, 8'ha2, 8'hf3, 8'h04);
    wr(`DRA_ADDR_MODE, {MODE_TRANS0, 5'h00});
    i_dra_l1_model_rx.send_frame(8'h01, 8'h02, 32, 1'b0);
    repeat (10) @(posedge SYS_CLK_I);
    chk(8'(pools), 8'h01);
    // counts frozen at pool full, the later frame end must not move them
    rd(`DRA_ADDR_COUNT_LOW, v);
    chk(v, 8'h20);
    wr(`DRA_ADDR_COMMAND, 8'h40);
    $display("test done: pool full");
    stop_test();
  end
endmodule
